//--- verilog/bbu_unit.sv
// The register addresses and the APB interface to the registers are this design's own decisions.
module bbu_unit (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [bbu_pkg::AW-1:0] paddr,
    input wire logic [bbu_pkg::DW-1:0] pwdata,
    output logic [bbu_pkg::DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic mem_req,
    output logic mem_we,
    output logic [bbu_pkg::DW-1:0] mem_addr,
    output logic [bbu_pkg::DW-1:0] mem_wdata,
    input wire logic [bbu_pkg::DW-1:0] mem_rdata,
    input wire logic mem_ack
);
    import bbu_pkg::*;

    typedef struct packed {
        bbu_st_e st;
        bbu_op_e op;
        bbu_cc_e cc;
        logic [DW-1:0] opa;
        logic [DW-1:0] opb;
        logic [DW-1:0] sel;
        logic [DW-1:0] flags;
        logic [DW-1:0] ip;
        logic [DW-1:0] cs;
        logic [DW-1:0] sp;
        logic [DW-1:0] res;
        logic [DW-1:0] tgt;
        logic [DW-1:0] wd;
        logic [1:0] idx;
        logic far;
        logic gate;
        logic req;
        logic we;
    } bbu_state_s;

    bbu_state_s state_reg;
    bbu_state_s state_next;
    logic access;
    logic wr;
    logic mapped;

    ////////////////////////////////////////////////////////////////////////
    // apb slave: stalls while an operation runs

    assign access = psel & penable;
    assign pready = (state_reg.st == S_IDLE);
    assign wr = access & pwrite & pready;
    assign mapped = (paddr[1:0] == 2'h0) && (paddr <= A_RES);
    assign pslverr = access & pready & ~mapped;
    assign mem_req = state_reg.req;
    assign mem_we = state_reg.we;
    assign mem_addr = state_reg.sp;
    assign mem_wdata = state_reg.wd;

    always_comb begin
        prdata = RST_WORD;
        if (paddr == A_CTRL) begin
            prdata[4:0] = state_reg.op;
            prdata[11:8] = state_reg.cc;
            prdata[BUSY_BIT] = (state_reg.st != S_IDLE);
            prdata[GATE_BIT] = state_reg.gate;
        end else if (paddr == A_OPA) begin
            prdata = state_reg.opa;
        end else if (paddr == A_OPB) begin
            prdata = state_reg.opb;
        end else if (paddr == A_SEL) begin
            prdata = state_reg.sel;
        end else if (paddr == A_FLAGS) begin
            prdata = state_reg.flags;
        end else if (paddr == A_IP) begin
            prdata = state_reg.ip;
        end else if (paddr == A_CS) begin
            prdata = state_reg.cs;
        end else if (paddr == A_SP) begin
            prdata = state_reg.sp;
        end else if (paddr == A_RES) begin
            prdata = state_reg.res;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // stack word for a push slot

    function automatic logic [DW-1:0] push_word(input logic [1:0] i, input bbu_state_s s);
        if (i == IDX_FLAGS) begin
            push_word = s.flags;
        end else if (i == IDX_CS) begin
            push_word = s.cs;
        end else begin
            push_word = s.ip;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic [4:0] off;
        logic [DW-1:0] mask;
        logic [DW-1:0] andv;
        logic [4:0] fidx;
        logic [4:0] ridx;
        logic last;
        off = state_reg.opb[4:0];
        mask = RST_WORD;
        mask[off] = 1'b1;
        andv = state_reg.opa & state_reg.opb;
        fidx = 5'h0;
        ridx = 5'h0;
        last = 1'b0;
        for (int i = DW - 1; i >= 0; i--) begin
            if (state_reg.opa[i]) begin
                fidx = 5'(i);
            end
        end
        for (int i = 0; i < DW; i++) begin
            if (state_reg.opa[i]) begin
                ridx = 5'(i);
            end
        end
        state_next = state_reg;
        if (wr) begin
            if (paddr == A_CTRL) begin
                if (pwdata[CTRL_GO_BIT]) begin
                    state_next.op = bbu_op_e'(pwdata[4:0]);
                    state_next.cc = bbu_cc_e'(pwdata[11:8]);
                    state_next.st = S_EXEC;
                end
            end else if (paddr == A_OPA) begin
                state_next.opa = pwdata;
            end else if (paddr == A_OPB) begin
                state_next.opb = pwdata;
            end else if (paddr == A_SEL) begin
                state_next.sel = pwdata;
            end else if (paddr == A_FLAGS) begin
                state_next.flags = pwdata;
            end else if (paddr == A_IP) begin
                state_next.ip = pwdata;
            end else if (paddr == A_CS) begin
                state_next.cs = pwdata;
            end else if (paddr == A_SP) begin
                state_next.sp = pwdata;
            end
        end
        case (state_reg.st)
            S_EXEC: begin
                state_next.st = S_IDLE;
                state_next.gate = 1'b0;
                state_next.far = 1'b0;
                case (state_reg.op)
                    OP_BIT_TEST, OP_BIT_SET, OP_BIT_CLR, OP_BIT_INV: begin
                        state_next.flags[FLG_CARRY] = state_reg.opa[off];
                        case (state_reg.op)
                            OP_BIT_SET: state_next.res = state_reg.opa | mask;
                            OP_BIT_CLR: state_next.res = state_reg.opa & ~mask;
                            OP_BIT_INV: state_next.res = state_reg.opa ^ mask;
                            default: state_next.res = state_reg.opa;
                        endcase
                    end
                    OP_SCAN_FWD, OP_SCAN_REV: begin
                        state_next.flags[FLG_ZERO] = (state_reg.opa == RST_WORD);
                        if (state_reg.opa != RST_WORD) begin
                            state_next.res = {27'h0, (state_reg.op == OP_SCAN_FWD) ? fidx : ridx};
                        end
                    end
                    OP_FLAG_BYTE: begin
                        state_next.res = {31'h0, bbu_cond(state_reg.cc, state_reg.flags)};
                    end
                    OP_TEST: begin
                        state_next.flags[FLG_SIGN] = andv[DW-1];
                        state_next.flags[FLG_ZERO] = (andv == RST_WORD);
                        state_next.flags[FLG_PARITY] = ~^andv[7:0];
                    end
                    OP_JCC: begin
                        if (bbu_cond(state_reg.cc, state_reg.flags)) begin
                            state_next.ip = state_reg.ip + state_reg.opb;
                        end
                    end
                    OP_JUMP_REL: begin
                        state_next.ip = state_reg.ip + state_reg.opb;
                    end
                    OP_JUMP_NEAR: begin
                        state_next.ip = state_reg.opb;
                    end
                    OP_JUMP_FAR, OP_JUMP_GATE: begin
                        state_next.cs = state_reg.sel;
                        state_next.ip = state_reg.opb;
                        state_next.gate = (state_reg.op == OP_JUMP_GATE);
                    end
                    OP_CALL_REL, OP_CALL_NEAR, OP_CALL_FAR, OP_INTR: begin
                        state_next.tgt = (state_reg.op == OP_CALL_REL) ? state_reg.ip + state_reg.opb
                            : state_reg.opb;
                        state_next.far = (state_reg.op == OP_CALL_FAR) || (state_reg.op == OP_INTR);
                        if (state_reg.op == OP_INTR) begin
                            state_next.idx = IDX_FLAGS;
                        end else if (state_reg.op == OP_CALL_FAR) begin
                            state_next.idx = IDX_CS;
                        end else begin
                            state_next.idx = IDX_IP;
                        end
                        state_next.wd = push_word(state_next.idx, state_reg);
                        state_next.sp = state_reg.sp - STK_STEP;
                        state_next.req = 1'b1;
                        state_next.we = 1'b1;
                        state_next.st = S_PUSH;
                    end
                    OP_BACK, OP_EXIT: begin
                        state_next.idx = IDX_FLAGS;
                        state_next.req = 1'b1;
                        state_next.we = 1'b0;
                        state_next.st = S_POP;
                    end
                    default: begin
                        state_next.st = S_IDLE;
                    end
                endcase
            end
            S_PUSH: begin
                if (mem_ack) begin
                    if (state_reg.idx == IDX_IP) begin
                        state_next.req = 1'b0;
                        state_next.we = 1'b0;
                        state_next.ip = state_reg.tgt;
                        if (state_reg.far) begin
                            state_next.cs = state_reg.sel;
                        end
                        state_next.st = S_IDLE;
                    end else begin
                        state_next.idx = state_reg.idx + 2'h1;
                        state_next.wd = push_word(state_next.idx, state_reg);
                        state_next.sp = state_reg.sp - STK_STEP;
                    end
                end
            end
            S_POP: begin
                if (mem_ack) begin
                    last = (state_reg.op == OP_BACK) || (state_reg.idx == 2'h2);
                    if (state_reg.idx == 2'h0) begin
                        state_next.ip = mem_rdata;
                    end else if (state_reg.idx == 2'h1) begin
                        state_next.cs = mem_rdata;
                    end else begin
                        state_next.flags = mem_rdata;
                    end
                    state_next.sp = state_reg.sp + STK_STEP;
                    state_next.idx = state_reg.idx + 2'h1;
                    if (last) begin
                        state_next.req = 1'b0;
                        state_next.st = S_IDLE;
                        if (state_reg.op == OP_BACK) begin
                            state_next.sp = state_reg.sp + STK_STEP + state_reg.opb;
                        end
                    end
                end
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic ex;
    assign ex = (state_reg.st == S_EXEC);

    property p_bit_carry;
        ex && (state_reg.op inside {OP_BIT_TEST, OP_BIT_SET, OP_BIT_CLR, OP_BIT_INV})
            |=> state_reg.flags[FLG_CARRY] == $past(state_reg.opa[state_reg.opb[4:0]]);
    endproperty
    a_bit_carry: assert property (p_bit_carry) else $error("carry not loaded from bit");

    property p_bit_inv;
        ex && state_reg.op == OP_BIT_INV
            |=> state_reg.res == ($past(state_reg.opa) ^ (32'h0000_0001 << $past(state_reg.opb[4:0])));
    endproperty
    a_bit_inv: assert property (p_bit_inv) else $error("invert result wrong");

    property p_bit_set;
        ex && state_reg.op == OP_BIT_SET
            |=> state_reg.res == ($past(state_reg.opa) | (32'h0000_0001 << $past(state_reg.opb[4:0])));
    endproperty
    a_bit_set: assert property (p_bit_set) else $error("set result wrong");

    property p_scan_fwd;
        ex && state_reg.op == OP_SCAN_FWD && state_reg.opa != RST_WORD
            |=> $stable(state_reg.opa) && state_reg.opa[state_reg.res[4:0]]
            && ((state_reg.opa & ((32'h0000_0001 << state_reg.res[4:0]) - 32'h0000_0001)) == RST_WORD);
    endproperty
    a_scan_fwd: assert property (p_scan_fwd) else $error("forward scan index wrong");

    property p_scan_rev;
        ex && state_reg.op == OP_SCAN_REV && state_reg.opa != RST_WORD
            |=> $stable(state_reg.opa) && ((state_reg.opa >> state_reg.res[4:0]) == 32'h0000_0001);
    endproperty
    a_scan_rev: assert property (p_scan_rev) else $error("reverse scan index wrong");

    property p_scan_zero;
        ex && state_reg.op inside {OP_SCAN_FWD, OP_SCAN_REV} && state_reg.opa == RST_WORD
            |=> state_reg.flags[FLG_ZERO] && $stable(state_reg.res);
    endproperty
    a_scan_zero: assert property (p_scan_zero) else $error("zero scan handling wrong");

    property p_ovfl_byte;
        ex && state_reg.op == OP_FLAG_BYTE && state_reg.cc == CC_O
            |=> state_reg.res == {31'h0, $past(state_reg.flags[FLG_OVFL])};
    endproperty
    a_ovfl_byte: assert property (p_ovfl_byte) else $error("overflow byte wrong");

    property p_test;
        ex && state_reg.op == OP_TEST
            |=> $stable(state_reg.opa) && $stable(state_reg.opb) && $stable(state_reg.res)
            && state_reg.flags[FLG_ZERO] == ((state_reg.opa & state_reg.opb) == RST_WORD);
    endproperty
    a_test: assert property (p_test) else $error("test result wrong");

    property p_jump_rel;
        ex && state_reg.op == OP_JUMP_REL
            |=> state_reg.ip == $past(state_reg.ip + state_reg.opb) && $stable(state_reg.sp) && !mem_req;
    endproperty
    a_jump_rel: assert property (p_jump_rel) else $error("relative jump wrong");

    property p_jump_near;
        ex && state_reg.op == OP_JUMP_NEAR
            |=> state_reg.ip == $past(state_reg.opb) && $stable(state_reg.cs) && !mem_req;
    endproperty
    a_jump_near: assert property (p_jump_near) else $error("near jump wrong");

    property p_jump_far;
        ex && state_reg.op inside {OP_JUMP_FAR, OP_JUMP_GATE}
            |=> state_reg.cs == $past(state_reg.sel) && state_reg.ip == $past(state_reg.opb) && !mem_req;
    endproperty
    a_jump_far: assert property (p_jump_far) else $error("far jump wrong");

    property p_cond_jump;
        ex && state_reg.op == OP_JCC && state_reg.cc == CC_E
            |=> state_reg.ip == ($past(state_reg.flags[FLG_ZERO]) ? $past(state_reg.ip + state_reg.opb)
            : $past(state_reg.ip));
    endproperty
    a_cond_jump: assert property (p_cond_jump) else $error("conditional jump wrong");

    property p_intr_push;
        ex && state_reg.op == OP_INTR
            |=> mem_req && mem_we && mem_wdata == $past(state_reg.flags) && state_reg.sp == $past(state_reg.sp) - STK_STEP;
    endproperty
    a_intr_push: assert property (p_intr_push) else $error("interrupt push wrong");

    property p_exit_flags;
        state_reg.st == S_POP && state_reg.op == OP_EXIT && state_reg.idx == 2'h2 && mem_ack
            |=> state_reg.flags == $past(mem_rdata) && !mem_req;
    endproperty
    a_exit_flags: assert property (p_exit_flags) else $error("flag word not restored");

    property p_call_push;
        ex && state_reg.op == OP_CALL_NEAR
            |=> mem_req && mem_we && state_reg.sp == $past(state_reg.sp) - STK_STEP && mem_wdata == $past(state_reg.ip);
    endproperty
    a_call_push: assert property (p_call_push) else $error("call push wrong");

    property p_back;
        state_reg.st == S_POP && state_reg.op == OP_BACK && mem_ack
            |=> state_reg.ip == $past(mem_rdata) && state_reg.sp == $past(state_reg.sp + STK_STEP + state_reg.opb);
    endproperty
    a_back: assert property (p_back) else $error("return wrong");
endmodule // bbu_unit

//--- verilog/bbu_pkg.sv
package bbu_pkg;
    localparam int DW = 32;
    localparam int AW = 8;
    localparam logic [AW-1:0] A_CTRL = 8'h00;
    localparam logic [AW-1:0] A_OPA = 8'h04;
    localparam logic [AW-1:0] A_OPB = 8'h08;
    localparam logic [AW-1:0] A_SEL = 8'h0c;
    localparam logic [AW-1:0] A_FLAGS = 8'h10;
    localparam logic [AW-1:0] A_IP = 8'h14;
    localparam logic [AW-1:0] A_CS = 8'h18;
    localparam logic [AW-1:0] A_SP = 8'h1c;
    localparam logic [AW-1:0] A_RES = 8'h20;
    localparam int FLG_CARRY = 0;
    localparam int FLG_PARITY = 1;
    localparam int FLG_ZERO = 2;
    localparam int FLG_SIGN = 3;
    localparam int FLG_OVFL = 4;
    localparam int CTRL_GO_BIT = 31;
    localparam int BUSY_BIT = 16;
    localparam int GATE_BIT = 17;
    localparam logic [DW-1:0] RST_WORD = 32'h0000_0000;
    localparam logic [DW-1:0] STK_STEP = 32'h0000_0004;
    localparam logic [1:0] IDX_FLAGS = 2'h0;
    localparam logic [1:0] IDX_CS = 2'h1;
    localparam logic [1:0] IDX_IP = 2'h2;

    typedef enum logic [4:0] {
        OP_BIT_TEST, OP_BIT_SET, OP_BIT_CLR, OP_BIT_INV, OP_SCAN_FWD, OP_SCAN_REV, OP_FLAG_BYTE, OP_TEST, OP_JCC,
        OP_JUMP_REL, OP_JUMP_NEAR, OP_JUMP_FAR, OP_JUMP_GATE, OP_CALL_REL, OP_CALL_NEAR,
        OP_CALL_FAR, OP_BACK, OP_INTR, OP_EXIT
    } bbu_op_e;

    typedef enum logic [3:0] {
        CC_O, CC_NO, CC_B, CC_AE, CC_E, CC_NE, CC_BE, CC_A,
        CC_S, CC_NS, CC_P, CC_NP, CC_L, CC_GE, CC_LE, CC_G
    } bbu_cc_e;

    typedef enum logic [1:0] {S_IDLE, S_EXEC, S_PUSH, S_POP} bbu_st_e;

    function automatic logic bbu_cond(input bbu_cc_e cc, input logic [DW-1:0] f);
        logic lt;
        lt = f[FLG_SIGN] ^ f[FLG_OVFL];
        case (cc)
            CC_O: bbu_cond = f[FLG_OVFL];
            CC_NO: bbu_cond = ~f[FLG_OVFL];
            CC_B: bbu_cond = f[FLG_CARRY];
            CC_AE: bbu_cond = ~f[FLG_CARRY];
            CC_E: bbu_cond = f[FLG_ZERO];
            CC_NE: bbu_cond = ~f[FLG_ZERO];
            CC_BE: bbu_cond = f[FLG_CARRY] | f[FLG_ZERO];
            CC_A: bbu_cond = ~(f[FLG_CARRY] | f[FLG_ZERO]);
            CC_S: bbu_cond = f[FLG_SIGN];
            CC_NS: bbu_cond = ~f[FLG_SIGN];
            CC_P: bbu_cond = f[FLG_PARITY];
            CC_NP: bbu_cond = ~f[FLG_PARITY];
            CC_L: bbu_cond = lt;
            CC_GE: bbu_cond = ~lt;
            CC_LE: bbu_cond = lt | f[FLG_ZERO];
            default: bbu_cond = ~(lt | f[FLG_ZERO]);
        endcase
    endfunction
endpackage

//--- verification/bbu_stack_mem.sv
module bbu_stack_mem (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    output logic [31:0] mem_rdata,
    output logic mem_ack,
    input wire logic [3:0] lag
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] mem [256];
    logic [3:0] wait_cnt;
    int n_acc;
    ////////////////////////////////////////
    // one word per ack; read bus toggles when not answering
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack <= 1'b0;
            wait_cnt <= 4'h0;
            n_acc <= 0;
            mem_rdata <= 32'h5a5a_5a5a;
        end else if (mem_req && !mem_ack && wait_cnt >= lag) begin
            mem_ack <= 1'b1;
            wait_cnt <= 4'h0;
            n_acc <= n_acc + 1;
            if (mem_we) begin
                mem[mem_addr[9:2]] <= mem_wdata;
            end else begin
                mem_rdata <= mem[mem_addr[9:2]];
            end
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_req && !mem_ack) begin
                wait_cnt <= wait_cnt + 4'h1;
            end
        end
    end
endmodule // bbu_stack_mem

//--- verification/tb.sv
module tb import bbu_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {
        bbu_op_e op;
        logic [DW-1:0] a, b, f, r, fx;
    } bbu_row_s;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_b;
    logic mem_req, mem_we, mem_ack, x, l;
    logic [AW-1:0] paddr;
    logic [DW-1:0] pwdata, prdata, mem_addr, mem_wdata, mem_rdata, rd, fl, keep;
    logic [3:0] lag;
    logic [7:0] v;
    int err_count, total_checks;
    bbu_row_s rows [9];

    bbu_unit uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack);
    bbu_stack_mem mdl (.pclk, .presetn, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .lag);

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    ////////////////////////////////////////
    task automatic chk(input string nm, input logic [DW-1:0] e, g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 400);
        if (n >= 400) chk("pready", 1'b1, pready);
        rd = prdata;
        err_b = pslverr;
    endtask

    task automatic exp_reg(input logic [AW-1:0] a, input logic [DW-1:0] e);
        apb(1'b0, a, '0);
        chk($sformatf("reg %h", a), e, rd);
    endtask

    task automatic exp_mem(input logic [DW-1:0] a, e);
        chk($sformatf("stack %h", a), e, mdl.mem[a[9:2]]);
    endtask

    task automatic go(input bbu_op_e op, input logic [3:0] cc, input logic [DW-1:0] a, b, f);
        logic [DW-1:0] c;
        c = '0;
        c[CTRL_GO_BIT] = 1'b1;
        c[11:8] = cc;
        c[4:0] = op;
        apb(1'b1, A_OPA, a);
        apb(1'b1, A_OPB, b);
        apb(1'b1, A_FLAGS, f);
        apb(1'b1, A_CTRL, c);
    endtask

    task automatic ctx(input logic [DW-1:0] ip, cs, sp, sel);
        apb(1'b1, A_IP, ip);
        apb(1'b1, A_CS, cs);
        apb(1'b1, A_SP, sp);
        apb(1'b1, A_SEL, sel);
    endtask

    task automatic where(input logic [DW-1:0] ip, cs, sp);
        exp_reg(A_IP, ip);
        exp_reg(A_CS, cs);
        exp_reg(A_SP, sp);
    endtask

    task automatic done(input string s);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        $display("test %s finished", s);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        #1_000_000;
        chk("watchdog", 1'b0, 1'b1);
        stop_test();
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        lag = 4'h0;
        rows = '{
            '{OP_BIT_TEST, 32'h0000_0010, 32'h0000_0004, 32'h0000_0000, 32'h0000_0010, 32'h0000_0001},
            '{OP_BIT_SET, 32'h0000_0000, 32'h0000_001f, 32'h0000_0001, 32'h8000_0000, 32'h0000_0000},
            '{OP_BIT_CLR, 32'hffff_ffff, 32'h0000_0000, 32'h0000_0000, 32'hffff_fffe, 32'h0000_0001},
            '{OP_BIT_INV, 32'h0000_0000, 32'h0000_0003, 32'h0000_0101, 32'h0000_0008, 32'h0000_0100},
            '{OP_BIT_INV, 32'h0000_0108, 32'h0000_0008, 32'h0000_0000, 32'h0000_0008, 32'h0000_0001},
            '{OP_SCAN_FWD, 32'h0000_0a00, 32'h0000_0000, 32'h0000_0004, 32'h0000_0009, 32'h0000_0000},
            '{OP_SCAN_REV, 32'h0000_0a00, 32'h0000_0000, 32'h0000_0000, 32'h0000_000b, 32'h0000_0000},
            '{OP_SCAN_REV, 32'h8000_0001, 32'h0000_0000, 32'h0000_0000, 32'h0000_001f, 32'h0000_0000},
            '{OP_SCAN_FWD, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_001f, 32'h0000_0004}
        };
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        exp_reg(A_SP, '0);
        exp_reg(A_CTRL, '0);
        done("reset");
        foreach (rows[i]) begin
            go(rows[i].op, 4'h0, rows[i].a, rows[i].b, rows[i].f);
            exp_reg(A_RES, rows[i].r);
            exp_reg(A_FLAGS, rows[i].fx);
        end
        done("bit rows");
        for (int k = 0; k < 48; k++) begin
            fl = (k < 16) ? 32'h0000_0014 : (k < 32) ? 32'h0000_0009 : 32'h0000_0002;
            l = fl[3] ^ fl[4];
            v = {l | fl[2], l, fl[1], fl[3], fl[0] | fl[2], fl[2], fl[0], fl[4]};
            x = v[k[3:1]] ^ k[0];
            go(OP_FLAG_BYTE, k[3:0], '0, '0, fl);
            exp_reg(A_RES, {31'b0, x});
        end
        go(OP_TEST, 4'h0, 32'h8000_0003, 32'h8000_0001, '0);
        exp_reg(A_FLAGS, 32'h0000_0008);
        exp_reg(A_OPA, 32'h8000_0003);
        exp_reg(A_OPB, 32'h8000_0001);
        go(OP_TEST, 4'h0, 32'h0000_00f0, 32'h0000_000f, 32'h0000_0008);
        exp_reg(A_FLAGS, 32'h0000_0006);
        done("flag ops");
        ctx(32'h0000_0100, 32'h0000_0003, 32'h0000_0200, 32'h0000_0008);
        go(OP_JUMP_REL, 4'h0, '0, 32'hffff_fff0, '0);
        where(32'h0000_00f0, 32'h0000_0003, 32'h0000_0200);
        go(OP_JCC, CC_E, '0, 32'h0000_0020, 32'h0000_0004);
        exp_reg(A_IP, 32'h0000_0110);
        go(OP_JCC, CC_E, '0, 32'h0000_0020, '0);
        exp_reg(A_IP, 32'h0000_0110);
        go(OP_JUMP_NEAR, 4'h0, '0, 32'h0000_1234, '0);
        where(32'h0000_1234, 32'h0000_0003, 32'h0000_0200);
        go(OP_JUMP_FAR, 4'h0, '0, 32'h0000_0200, '0);
        where(32'h0000_0200, 32'h0000_0008, 32'h0000_0200);
        chk("stack accesses", '0, mdl.n_acc);
        apb(1'b1, A_SEL, 32'h0000_0010);
        go(OP_JUMP_GATE, 4'h0, '0, 32'h0000_0300, '0);
        where(32'h0000_0300, 32'h0000_0010, 32'h0000_0200);
        apb(1'b0, A_CTRL, '0);
        chk("gate flag", 1'b1, rd[GATE_BIT]);
        done("jumps");
        lag <= 4'h3;
        ctx(32'h0000_0040, 32'h0000_0003, 32'h0000_0100, 32'h0000_0005);
        go(OP_CALL_NEAR, 4'h0, '0, 32'h0000_0010, '0);
        where(32'h0000_0010, 32'h0000_0003, 32'h0000_00fc);
        exp_mem(32'h0000_00fc, 32'h0000_0040);
        go(OP_CALL_FAR, 4'h0, '0, 32'h0000_0500, '0);
        where(32'h0000_0500, 32'h0000_0005, 32'h0000_00f4);
        exp_mem(32'h0000_00f8, 32'h0000_0003);
        exp_mem(32'h0000_00f4, 32'h0000_0010);
        go(OP_CALL_REL, 4'h0, '0, 32'h0000_0008, '0);
        where(32'h0000_0508, 32'h0000_0005, 32'h0000_00f0);
        exp_mem(32'h0000_00f0, 32'h0000_0500);
        go(OP_BACK, 4'h0, '0, '0, '0);
        where(32'h0000_0500, 32'h0000_0005, 32'h0000_00f4);
        go(OP_BACK, 4'h0, '0, 32'h0000_0008, '0);
        where(32'h0000_0010, 32'h0000_0005, 32'h0000_0100);
        done("calls");
        lag <= 4'h0;
        ctx(32'h0000_0060, 32'h0000_0007, 32'h0000_0200, 32'h0000_0009);
        go(OP_INTR, 4'h0, '0, 32'h0000_0800, 32'h0000_0015);
        where(32'h0000_0800, 32'h0000_0009, 32'h0000_01f4);
        exp_mem(32'h0000_01fc, 32'h0000_0015);
        exp_mem(32'h0000_01f8, 32'h0000_0007);
        exp_mem(32'h0000_01f4, 32'h0000_0060);
        go(OP_EXIT, 4'h0, '0, 32'h0000_0004, '0);
        where(32'h0000_0060, 32'h0000_0007, 32'h0000_0200);
        exp_reg(A_FLAGS, 32'h0000_0015);
        done("interrupt");
        apb(1'b0, A_RES, '0);
        keep = rd;
        apb(1'b1, A_RES, 32'h5555_aaaa);
        exp_reg(A_RES, keep);
        chk("slverr", 1'b0, err_b);
        apb(1'b0, 8'h24, '0);
        chk("slverr", 1'b1, err_b);
        apb(1'b1, 8'h06, 32'h0000_0001);
        chk("slverr", 1'b1, err_b);
        done("bus");
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        exp_reg(A_IP, '0);
        done("second reset");
        stop_test();
    end
endmodule // tb
